/* File: asb_regs.svh */
// Constants and register map of the acquisition band scheduler
// Notes on behaviour
// - Lowest band runs whole acquisition, 24 per second legacy, 15 current.
// - Slot length accepted from 1 to 59 minutes.
// - Slot sequence restarts at every UTC hour.
// - Highest and intermediate bands alternate between successive slots.
// - Odd slots take up to two one-second highest-band records on minutes.
// - Even slots take up to sixteen one-second intermediate-band records.
// - Highest band: 2560 legacy 50 Hz, 3072 legacy 60 Hz, 2400 current.
// - Intermediate band: 320 legacy 50 Hz, 384 legacy 60 Hz, 150 current.
// - Record sample counts follow line frequency and rate schedule.
// - Start passed under 12 hours ago acquires at once, else standby; a dated start from a previous day gives standby.
// - Undated times act daily; dated times act once.
// - Both window times zero means high bands recorded throughout.
// - Configured window limits high bands to window start until end.
// - Undated window repeats daily; window with both times dated applies once.
// - Times are UTC hours, minutes, seconds, optionally with date.
// - Empty file name becomes serial, month, day char, repeat index.
`ifndef ASB_REGS_SVH
`define ASB_REGS_SVH
// ----------------------------------------------------------------
// Register word indices
// ----------------------------------------------------------------
`define ASB_IDX_CTRL 4'h0
`define ASB_IDX_SLOT 4'h1
`define ASB_IDX_NOW_T 4'h2
`define ASB_IDX_NOW_D 4'h3
`define ASB_IDX_ST_T 4'h4
`define ASB_IDX_ST_D 4'h5
`define ASB_IDX_EN_T 4'h6
`define ASB_IDX_EN_D 4'h7
`define ASB_IDX_HS_T 4'h8
`define ASB_IDX_HS_D 4'h9
`define ASB_IDX_HE_T 4'ha
`define ASB_IDX_HE_D 4'hb
`define ASB_IDX_IDENT 4'hc
`define ASB_IDX_NAME_HI 4'hd
`define ASB_IDX_NAME_LO 4'he
`define ASB_IDX_STATUS 4'hf
`define ASB_NREG 16
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ASB_RUN_BIT 0
`define ASB_LINE60_BIT 1
`define ASB_LEGACY_BIT 2
`define ASB_DATED_BIT 31
`define ASB_LEN_MSB 5
`define ASB_HICNT_MSB 9
`define ASB_HICNT_LSB 8
`define ASB_MIDCNT_MSB 20
`define ASB_MIDCNT_LSB 16
`define ASB_TOD_MSB 16
`define ASB_DATE_MSB 20
`define ASB_SER_MSB 15
`define ASB_REP_MSB 23
`define ASB_REP_LSB 16
// ----------------------------------------------------------------
// Limits, rates and time
// ----------------------------------------------------------------
`define ASB_LEN_MIN 6'h01
`define ASB_LEN_MAX 6'h3b
`define ASB_HI_MAX 6'h02
`define ASB_MID_MAX 6'h10
`define ASB_LOW_LEG 5'h18
`define ASB_LOW_CUR 5'h0f
`define ASB_HI_L50 12'ha00
`define ASB_HI_L60 12'hc00
`define ASB_HI_CUR 12'h960
`define ASB_MID_L50 9'h140
`define ASB_MID_L60 9'h180
`define ASB_MID_CUR 9'h096
`define ASB_SEC_MAX 6'h3b
`define ASB_MIN_MAX 6'h3b
`define ASB_HOUR_MAX 5'h17
`define ASB_MONTH_MAX 4'hc
`define ASB_S_PER_H 3600
`define ASB_S_PER_M 60
`define ASB_DAY_S 18'h15180
`define ASB_HALF_DAY_S 17'ha8c0
`define ASB_CLK_HZ 100000000
`define ASB_SEC_S 1
`endif

/* File: asb_pkg.sv */
// Types and helpers of the acquisition band scheduler
`include "asb_regs.svh"
package asb_pkg;
    typedef struct packed {
        logic [11:0] year;
        logic [3:0] month;
        logic [4:0] day;
    } asb_date_t;
    typedef struct packed {
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
    } asb_tod_t;
    typedef struct packed {
        logic acquiring;
        logic low_en;
        logic [4:0] low_rate;
        logic hi_rec;
        logic [11:0] hi_rate;
        logic mid_rec;
        logic [8:0] mid_rate;
    } asb_band_t;
    typedef enum {ASB_OFF, ASB_STANDBY, ASB_ACQ, ASB_DONE} asb_state_t;

    function automatic logic [16:0] asb_sod(asb_tod_t t);
        return 17'(t.hour * `ASB_S_PER_H + t.min * `ASB_S_PER_M + t.sec);
    endfunction : asb_sod

    function automatic logic [4:0] asb_dim(asb_date_t d);
        logic [4:0] n;
        n = 5'h1f;
        if (d.month == 4'h2) begin
            n = (d.year[1:0] == 2'h0) ? 5'h1d : 5'h1c;
        end else if (d.month == 4'h4 || d.month == 4'h6 ||
                     d.month == 4'h9 || d.month == 4'hb) begin
            n = 5'h1e;
        end
        return n;
    endfunction : asb_dim

    function automatic logic [7:0] asb_chr(logic [4:0] v);
        return (v < 5'h0a) ? 8'(8'h30 + v) : 8'(8'h37 + v);
    endfunction : asb_chr
endpackage : asb_pkg

/* File: asb_scheduler.sv */
// Acquisition band scheduler with AHB-Lite register slave
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "asb_regs.svh"
module asb_scheduler import asb_pkg::*; #(
    parameter int unsigned CYC_PER_SEC = `ASB_SEC_S * `ASB_CLK_HZ
) (
    input logic hclk,
    input logic hresetn,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output asb_band_t band
);
    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic [31:0] cfg_reg [0:`ASB_NREG-1];
    logic wr_pend_reg;
    logic [3:0] wr_idx_reg;
    wire logic mapped = (haddr[31:6] == 26'h0);
    wire logic addr_ok = hsel && htrans[1] && hready;
    wire logic [3:0] idx = haddr[5:2];
    logic [31:0] rd_word;
    asb_tod_t now_tod;
    asb_date_t now_date;
    logic [63:0] name_w;
    logic [31:0] status_w;

    assign rd_word = !mapped ? 32'h0 :
        (idx == `ASB_IDX_NOW_T) ? {15'h0, now_tod} :
        (idx == `ASB_IDX_NOW_D) ? {11'h0, now_date} :
        (idx == `ASB_IDX_NAME_HI) ? name_w[63:32] :
        (idx == `ASB_IDX_NAME_LO) ? name_w[31:0] :
        (idx == `ASB_IDX_STATUS) ? status_w : cfg_reg[idx];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 4'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_reg <= addr_ok && hwrite && mapped;
            wr_idx_reg <= idx;
            hrdata <= (addr_ok && !hwrite) ? rd_word : 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    wire logic cfg_we = wr_pend_reg &&
        wr_idx_reg != `ASB_IDX_NOW_T && wr_idx_reg != `ASB_IDX_NOW_D &&
        wr_idx_reg != `ASB_IDX_STATUS;
    wire logic load_t = wr_pend_reg && wr_idx_reg == `ASB_IDX_NOW_T;
    wire logic load_d = wr_pend_reg && wr_idx_reg == `ASB_IDX_NOW_D;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `ASB_NREG; i++) begin
                cfg_reg[i] <= 32'h0;
            end
        end else if (cfg_we) begin
            cfg_reg[wr_idx_reg] <= hwdata;
        end
    end

    // ------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------
    wire logic [31:0] ctrl = cfg_reg[`ASB_IDX_CTRL];
    wire logic [31:0] slot = cfg_reg[`ASB_IDX_SLOT];
    wire logic run = ctrl[`ASB_RUN_BIT];
    wire logic line60 = ctrl[`ASB_LINE60_BIT];
    wire logic legacy = ctrl[`ASB_LEGACY_BIT];
    wire logic [5:0] len_raw = slot[`ASB_LEN_MSB:0];
    wire logic [5:0] hi_raw = {4'h0, slot[`ASB_HICNT_MSB:`ASB_HICNT_LSB]};
    wire logic [5:0] mid_raw = {1'b0, slot[`ASB_MIDCNT_MSB:`ASB_MIDCNT_LSB]};
    wire logic [5:0] slot_len = (len_raw < `ASB_LEN_MIN) ? `ASB_LEN_MIN :
        (len_raw > `ASB_LEN_MAX) ? `ASB_LEN_MAX : len_raw;
    wire logic [5:0] hi_cnt = (hi_raw > `ASB_HI_MAX) ? `ASB_HI_MAX : hi_raw;
    wire logic [5:0] mid_cnt =
        (mid_raw > `ASB_MID_MAX) ? `ASB_MID_MAX : mid_raw;

    // ------------------------------------------------------------
    // UTC timebase
    // ------------------------------------------------------------
    logic [31:0] div_reg;
    wire logic tick = (div_reg == CYC_PER_SEC - 1);
    wire logic sec_end = (now_tod.sec == `ASB_SEC_MAX);
    wire logic min_end = sec_end && (now_tod.min == `ASB_MIN_MAX);
    wire logic hour_end = min_end && (now_tod.hour == `ASB_HOUR_MAX);
    wire logic mon_end = (now_date.day == asb_dim(now_date));
    asb_tod_t tod_next;
    asb_date_t date_next;

    assign tod_next.sec = sec_end ? 6'h0 : 6'(now_tod.sec + 6'h1);
    assign tod_next.min = !sec_end ? now_tod.min :
        min_end ? 6'h0 : 6'(now_tod.min + 6'h1);
    assign tod_next.hour = !min_end ? now_tod.hour :
        hour_end ? 5'h0 : 5'(now_tod.hour + 5'h1);
    assign date_next.day = mon_end ? 5'h1 : 5'(now_date.day + 5'h1);
    assign date_next.month = !mon_end ? now_date.month :
        (now_date.month == `ASB_MONTH_MAX) ? 4'h1 :
        4'(now_date.month + 4'h1);
    assign date_next.year = (mon_end && now_date.month == `ASB_MONTH_MAX) ?
        12'(now_date.year + 12'h1) : now_date.year;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= 32'h0;
            now_tod <= '0;
            now_date <= '0;
        end else begin
            div_reg <= (tick || load_t) ? 32'h0 : div_reg + 32'h1;
            if (load_t) begin
                now_tod <= hwdata[`ASB_TOD_MSB:0];
            end else if (tick) begin
                now_tod <= tod_next;
            end
            if (load_d) begin
                now_date <= hwdata[`ASB_DATE_MSB:0];
            end else if (tick && hour_end) begin
                now_date <= date_next;
            end
        end
    end

    // ------------------------------------------------------------
    // Schedule times
    // ------------------------------------------------------------
    wire logic [37:0] now_stamp = {now_date, now_tod};
    wire logic [16:0] now_sod = asb_sod(now_tod);
    wire logic [31:0] st_t = cfg_reg[`ASB_IDX_ST_T];
    wire logic [31:0] en_t = cfg_reg[`ASB_IDX_EN_T];
    wire logic [31:0] hs_t = cfg_reg[`ASB_IDX_HS_T];
    wire logic [31:0] he_t = cfg_reg[`ASB_IDX_HE_T];
    wire logic [37:0] st_stamp = {cfg_reg[`ASB_IDX_ST_D][`ASB_DATE_MSB:0],
        st_t[`ASB_TOD_MSB:0]};
    wire logic [37:0] en_stamp = {cfg_reg[`ASB_IDX_EN_D][`ASB_DATE_MSB:0],
        en_t[`ASB_TOD_MSB:0]};
    wire logic [37:0] hs_stamp = {cfg_reg[`ASB_IDX_HS_D][`ASB_DATE_MSB:0],
        hs_t[`ASB_TOD_MSB:0]};
    wire logic [37:0] he_stamp = {cfg_reg[`ASB_IDX_HE_D][`ASB_DATE_MSB:0],
        he_t[`ASB_TOD_MSB:0]};
    wire logic [16:0] st_sod = asb_sod(st_t[`ASB_TOD_MSB:0]);
    wire logic [16:0] en_sod = asb_sod(en_t[`ASB_TOD_MSB:0]);
    wire logic [16:0] hs_sod = asb_sod(hs_t[`ASB_TOD_MSB:0]);
    wire logic [16:0] he_sod = asb_sod(he_t[`ASB_TOD_MSB:0]);
    wire logic st_dated = st_t[`ASB_DATED_BIT];
    wire logic en_dated = en_t[`ASB_DATED_BIT];
    wire logic hw_dated = hs_t[`ASB_DATED_BIT] && he_t[`ASB_DATED_BIT];

    wire logic start_hit = st_dated ? (now_stamp == st_stamp) :
        (now_sod == st_sod);
    wire logic end_hit = en_dated ? (now_stamp == en_stamp) :
        (now_sod == en_sod);
    wire logic [16:0] elapsed = (now_sod >= st_sod) ?
        17'(now_sod - st_sod) : 17'(18'(now_sod) + `ASB_DAY_S - st_sod);
    wire logic late_ok = (elapsed < `ASB_HALF_DAY_S) && (!st_dated ||
        (now_date == st_stamp[37:17] && now_sod >= st_sod));

    wire logic win_off = !hs_t[`ASB_DATED_BIT] && !he_t[`ASB_DATED_BIT] &&
        hs_sod == 17'h0 && he_sod == 17'h0;
    wire logic win_day = (hs_sod <= he_sod) ?
        (now_sod >= hs_sod && now_sod < he_sod) :
        (now_sod >= hs_sod || now_sod < he_sod);
    wire logic win_once = now_stamp >= hs_stamp && now_stamp < he_stamp;
    wire logic win_ok = win_off ||
        (hw_dated ? win_once : win_day);

    // ------------------------------------------------------------
    // Acquisition state
    // ------------------------------------------------------------
    asb_state_t state_reg;
    asb_state_t state_next;
    logic run_q_reg;
    wire logic run_rise = run && !run_q_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ASB_OFF: begin
                if (run_rise) begin
                    state_next = late_ok ? ASB_ACQ : ASB_STANDBY;
                end
            end
            ASB_STANDBY: begin
                if (tick && start_hit) begin
                    state_next = ASB_ACQ;
                end
            end
            ASB_ACQ: begin
                if (tick && end_hit) begin
                    state_next = en_dated ? ASB_DONE : ASB_STANDBY;
                end
            end
            ASB_DONE: begin
                state_next = ASB_DONE;
            end
        endcase
        if (!run) begin
            state_next = ASB_OFF;
        end
    end

    // ------------------------------------------------------------
    // Slot tracking
    // ------------------------------------------------------------
    logic [5:0] slot_num_reg;
    logic [5:0] min_in_reg;
    wire logic slot_wrap = (6'(min_in_reg + 6'h1) >= slot_len);
    asb_date_t name_date_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ASB_OFF;
            run_q_reg <= 1'b0;
            slot_num_reg <= 6'h1;
            min_in_reg <= 6'h0;
            name_date_reg <= '0;
        end else begin
            state_reg <= state_next;
            run_q_reg <= run;
            if (state_next == ASB_ACQ && state_reg != ASB_ACQ) begin
                name_date_reg <= now_date;
            end
            if (load_t || (tick && min_end)) begin
                slot_num_reg <= 6'h1;
                min_in_reg <= 6'h0;
            end else if (tick && sec_end) begin
                slot_num_reg <= slot_wrap ?
                    6'(slot_num_reg + 6'h1) : slot_num_reg;
                min_in_reg <= slot_wrap ? 6'h0 : 6'(min_in_reg + 6'h1);
            end
        end
    end

    // ------------------------------------------------------------
    // Band control and file name
    // ------------------------------------------------------------
    wire logic acq = (state_reg == ASB_ACQ);
    wire logic rec_sec = acq && win_ok && now_tod.sec == 6'h0;
    asb_band_t band_next;
    assign band_next.acquiring = acq;
    assign band_next.low_en = acq;
    assign band_next.low_rate = legacy ? `ASB_LOW_LEG : `ASB_LOW_CUR;
    assign band_next.hi_rec = rec_sec && slot_num_reg[0] &&
        min_in_reg < hi_cnt;
    assign band_next.mid_rec = rec_sec && !slot_num_reg[0] &&
        min_in_reg < mid_cnt;
    assign band_next.hi_rate = !legacy ? `ASB_HI_CUR :
        line60 ? `ASB_HI_L60 : `ASB_HI_L50;
    assign band_next.mid_rate = !legacy ? `ASB_MID_CUR :
        line60 ? `ASB_MID_L60 : `ASB_MID_L50;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            band <= '0;
        end else begin
            band <= band_next;
        end
    end

    wire logic [31:0] ident = cfg_reg[`ASB_IDX_IDENT];
    wire logic [15:0] ser = ident[`ASB_SER_MSB:0];
    wire logic [7:0] rep = ident[`ASB_REP_MSB:`ASB_REP_LSB];
    wire logic [63:0] name_cfg =
        {cfg_reg[`ASB_IDX_NAME_HI], cfg_reg[`ASB_IDX_NAME_LO]};
    wire logic [63:0] name_auto = {asb_chr({1'b0, ser[15:12]}),
        asb_chr({1'b0, ser[11:8]}), asb_chr({1'b0, ser[7:4]}),
        asb_chr({1'b0, ser[3:0]}), asb_chr({1'b0, name_date_reg.month}),
        asb_chr(name_date_reg.day), asb_chr({1'b0, rep[7:4]}),
        asb_chr({1'b0, rep[3:0]})};
    assign name_w = (name_cfg != 64'h0) ? name_cfg : name_auto;
    assign status_w = {10'h0, min_in_reg, 2'h0, slot_num_reg, 4'h0,
        band.mid_rec, band.hi_rec, 2'(state_reg)};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_low_rate_sel:
        assert property (band.acquiring |-> band.low_en &&
            band.low_rate == ($past(legacy) ? 5'h18 : 5'h0f))
        else $error("lowest band rate wrong");
    a_slot_len_rng:
        assert property (slot_len >= 6'h01 && slot_len <= 6'h3b)
        else $error("slot length out of range");
    a_hour_restart:
        assert property (tick && min_end && !load_t |=>
            slot_num_reg == 6'h1 && min_in_reg == 6'h0)
        else $error("slot pattern not restarted at hour");
    a_hi_odd_slot:
        assert property (band.hi_rec |-> $past(slot_num_reg[0]) &&
            !band.mid_rec)
        else $error("highest band captured in even slot");
    a_hi_rec_count:
        assert property (band.hi_rec |-> $past(min_in_reg) < 6'h02 &&
            $past(now_tod.sec) == 6'h0)
        else $error("highest band record misplaced");
    a_mid_rec_count:
        assert property (band.mid_rec |-> $past(min_in_reg) < 6'h10 &&
            !$past(slot_num_reg[0]))
        else $error("intermediate band record misplaced");
    a_hi_rate_sel:
        assert property ($past(hresetn) |-> band.hi_rate ==
            (!$past(legacy) ? 12'd2400 :
            $past(line60) ? 12'd3072 : 12'd2560))
        else $error("highest band rate wrong");
    a_mid_rate_sel:
        assert property ($past(hresetn) |-> band.mid_rate ==
            (!$past(legacy) ? 9'd150 :
            $past(line60) ? 9'd384 : 9'd320))
        else $error("intermediate band rate wrong");
    a_late_start:
        assert property (state_reg == ASB_OFF && run_rise && late_ok
            |=> state_reg == ASB_ACQ ##1 band.acquiring)
        else $error("late start did not acquire at once");
    a_window_gate:
        assert property ((band.hi_rec || band.mid_rec) |-> $past(win_ok))
        else $error("high band captured outside window");
endmodule : asb_scheduler

/* File: asb_channels_model.sv */
// Converter channel model driven by the band control word
`timescale 1ns/10ps
module asb_channels_model import asb_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire asb_band_t band,
    output logic hi_seen,
    output logic mid_seen,
    output int rec_len
);
    logic hi_q;
    logic mid_q;
    int run_len;
    // ----------------------------------------------------------------
    // Record starts on each high band
    // ----------------------------------------------------------------
    assign hi_seen = band.hi_rec & ~hi_q;
    assign mid_seen = band.mid_rec & ~mid_q;
    // ----------------------------------------------------------------
    // Length of the last finished record in clock cycles
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hi_q <= 1'b0;
            mid_q <= 1'b0;
            run_len <= 0;
            rec_len <= 0;
        end else begin
            hi_q <= band.hi_rec;
            mid_q <= band.mid_rec;
            if (band.hi_rec | band.mid_rec) begin
                run_len <= run_len + 1;
            end else begin
                if (run_len != 0) begin
                    rec_len <= run_len;
                end
                run_len <= 0;
            end
        end
    end
endmodule : asb_channels_model

/* File: asb_scheduler_test.sv */
// Self-checking testbench of the acquisition band scheduler
`timescale 1ns/10ps
module asb_scheduler_test import asb_pkg::*;;
    localparam int CPS = 4;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    asb_band_t band;
    logic hi_seen;
    logic mid_seen;
    int rec_len;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int seed = 18248;
    logic [31:0] rd;
    logic [31:0] v;
    int q[$];
    int k;
    int s;
    int mm;
    // ----------------------------------------------------------------
    // Design, channel model, clock and timeout
    // ----------------------------------------------------------------
    assign hready = hreadyout;
    asb_scheduler #(.CYC_PER_SEC(CPS)) uut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .band(band));
    asb_channels_model chan (.hclk(hclk), .hresetn(hresetn), .band(band),
        .hi_seen(hi_seen), .mid_seen(mid_seen), .rec_len(rec_len));
    always #5 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad_count = bad_count + 1;
            finish_test();
        end
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test();
        if (bad_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb
    function automatic logic [31:0] tod(int h, int m, int sec);
        return {15'h0, 5'(h), 6'(m), 6'(sec)};
    endfunction : tod
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        check({2'h0, band}, 32'h0);
        ahb(1'b0, 32'h3c, 32'h0);
        check(rd, 32'h00000100);
        ahb(1'b0, 32'h40, 32'h0);
        check(rd, 32'h0);
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            ahb(1'b1, 32'h04, v);
            ahb(1'b0, 32'h04, 32'h0);
            check(rd, v);
        end
        ahb(1'b1, 32'h30, 32'h000a1234);
        ahb(1'b1, 32'h0c, {11'h0, 12'h7e8, 4'hc, 5'h1f});
        ahb(1'b1, 32'h04, 32'h00030207);
        ahb(1'b1, 32'h18, tod(23, 0, 0));
        ahb(1'b1, 32'h10, tod(11, 0, 0));
        ahb(1'b1, 32'h08, tod(23, 30, 0));
        ahb(1'b1, 32'h00, 32'h5);
        ahb(1'b0, 32'h3c, 32'h0);
        check({30'h0, rd[1:0]}, 32'h1);
        ahb(1'b1, 32'h00, 32'h4);
        ahb(1'b1, 32'h10, tod(23, 59, 40));
        ahb(1'b1, 32'h08, tod(23, 59, 50));
        ahb(1'b1, 32'h00, 32'h5);
        ahb(1'b0, 32'h3c, 32'h0);
        check({30'h0, rd[1:0]}, 32'h2);
        ahb(1'b0, 32'h34, 32'h0);
        check(rd, 32'h31323334);
        ahb(1'b0, 32'h38, 32'h0);
        check(rd, 32'h43563041);
        for (int m = 0; m <= 60; m++) begin
            mm = m % 60;
            s = mm / 7 + 1;
            k = mm % 7;
            if (s % 2 == 1 && k < 2) begin
                q.push_back(1);
            end else if (s % 2 == 0 && k < 3) begin
                q.push_back(0);
            end
        end
        for (int n = 0; n < q.size(); n++) begin
            k = 0;
            do begin
                @(posedge hclk);
                k++;
            end while (!(hi_seen | mid_seen) && k < 2000);
            check(32'(k < 2000), 32'h1);
            check({31'h0, hi_seen}, 32'(q[n]));
            check({31'h0, band.acquiring}, 32'h1);
            if (n > 0) begin
                check(32'(rec_len), 32'(CPS));
            end
        end
        for (int c = 0; c < 4; c++) begin
            ahb(1'b1, 32'h00, {29'h0, ~c[1], c[0], 1'b1});
            repeat (3) @(posedge hclk);
            check({31'h0, band.low_en}, 32'h1);
            check({27'h0, band.low_rate},
                  c[1] ? 32'h0f : 32'h18);
            check({20'h0, band.hi_rate}, c[1] ? 32'h960 :
                  c[0] ? 32'hc00 : 32'ha00);
            check({23'h0, band.mid_rate}, c[1] ? 32'h096 :
                  c[0] ? 32'h180 : 32'h140);
        end
        // Undated window that excludes the present hour
        ahb(1'b1, 32'h20, tod(2, 0, 0));
        ahb(1'b1, 32'h28, tod(3, 0, 0));
        k = 0;
        repeat (300) begin
            @(posedge hclk);
            k = k + 32'(hi_seen | mid_seen);
        end
        check(32'(k), 32'h0);
        finish_test();
    end
endmodule : asb_scheduler_test
